/* hdl/acgcd_pkg.sv */
package acgcd_pkg;

  // Command byte decode patterns
  localparam logic [2:0] AVG_SEL_PAT = 3'h1;
  localparam logic [3:0] DAC_SEL_PAT = 4'h1;
  localparam logic [4:0] RST_SEL_PAT = 5'h01;
  localparam logic [5:0] PIN_SEL_PAT = 6'h00;
  localparam logic [1:0] PIN_CFG_CODE = 2'h3;
  localparam logic [1:0] PIN_WR_CODE = 2'h2;
  localparam logic [1:0] PIN_RD_CODE = 2'h1;

  // Field positions in the command byte
  localparam int AVG_EN_BIT = 4;
  localparam int AVG_DEPTH_LSB = 2;
  localparam int AVG_COUNT_LSB = 0;
  localparam int RST_FULL_BIT = 2;
  localparam int RST_SLOW_BIT = 1;
  localparam int RST_FBG_BIT = 0;

  // Index of the last bit in each phase of the serial frame (8, 16 and 8 bits)
  localparam logic [3:0] CMD_LAST = 4'h7;
  localparam logic [3:0] DAC_LAST = 4'hF;
  localparam logic [3:0] PIN_LAST = 4'h7;

  // Mode codes of the conversion engine
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] CLK_MODE_01 = 2'h1;
  localparam logic [1:0] CLK_MODE_11 = 2'h3;

  // Values after reset
  localparam logic [4:0] AVG_RESET = 5'h00;
  localparam logic [7:0] SETUP_RESET = 8'h60;
  localparam logic [3:0] PIN_CFG_RESET = 4'h0;
  // Write bits high so unconfigured pins float as inputs, not pull down
  localparam logic [3:0] PIN_WR_RESET = 4'hF;

  // Link frame phases
  typedef enum logic [3:0] {
    PH_CMD = 4'h1,
    PH_DAC = 4'h2,
    PH_PWR = 4'h4,
    PH_PRD = 4'h8
  } acgcd_phase_t;

  // Completed command kinds handed to the system clock
  typedef enum logic [4:0] {
    EV_NONE = 5'h00,
    EV_AVG = 5'h01,
    EV_RST = 5'h02,
    EV_DAC = 5'h04,
    EV_CFG = 5'h08,
    EV_WR = 5'h10
  } acgcd_event_t;

  typedef struct packed {
    acgcd_phase_t phase;
    logic [3:0] cnt;
    logic [15:0] shift;
    logic wr_kind;
    logic dout;
  } acgcd_frame_t;

  typedef struct packed {
    logic tgl;
    acgcd_event_t kind;
    logic [15:0] word;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
  } acgcd_link_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic [4:0] avg;
    logic slow;
    logic fbg;
    logic [3:0] cfg;
    logic [3:0] wr;
    logic cfg_pend;
    logic wr_pend;
    logic [3:0] cfg_data;
    logic [3:0] wr_data;
    logic [15:0] dac_word;
    logic dac_stb;
    logic fifo_clr;
    logic regs_rst;
  } acgcd_core_t;

endpackage

/* hdl/acgcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

module acgcd_decoder #(
  parameter int NPINS = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic link_sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  input wire logic [1:0] scan_mode_i,
  input wire logic [1:0] clock_mode_i,
  output logic averaging_enable_o,
  output logic [1:0] average_depth_o,
  output logic [1:0] repeat_count_o,
  output logic [5:0] conversions_per_result_o,
  output logic [4:0] scan_results_o,
  output logic fifo_clear_o,
  output logic regs_reset_o,
  output logic [7:0] setup_reset_value_o,
  output logic slow_mode_o,
  output logic force_reference_on_o,
  output logic wake_delay_bypass_o,
  output logic [15:0] dac_word_o,
  output logic dac_strobe_o,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_n_o
);

  localparam acgcd_pkg::acgcd_frame_t FRAME_RESET = '{
    phase: acgcd_pkg::PH_CMD, cnt: 4'h0, shift: 16'h0000, wr_kind: 1'b0, dout: 1'b0};
  localparam acgcd_pkg::acgcd_link_t LINK_RESET = '{
    tgl: 1'b0, kind: acgcd_pkg::EV_NONE, word: 16'h0000, pin_s1: 4'h0, pin_s2: 4'h0};

  acgcd_pkg::acgcd_frame_t fr_reg;
  acgcd_pkg::acgcd_frame_t fr_next;
  acgcd_pkg::acgcd_link_t lk_reg;
  acgcd_pkg::acgcd_link_t lk_next;
  acgcd_pkg::acgcd_core_t core_reg;
  acgcd_pkg::acgcd_core_t core_next;
  logic frame_clr;
  logic [15:0] shifted;
  logic [7:0] cmd_byte;

  // A raised chip select wipes the frame; the sclk may be stopped then
  assign frame_clr = reset_i | cs_n_i;
  assign shifted = {fr_reg.shift[14:0], din_i};
  assign cmd_byte = shifted[7:0];

  // Link side, falling sclk edge
  always_comb
  begin
    fr_next = fr_reg;
    lk_next = lk_reg;
    lk_next.pin_s1 = pin_i[3:0];
    lk_next.pin_s2 = lk_reg.pin_s1;
    fr_next.cnt = 4'(fr_reg.cnt + 4'h1);
    fr_next.shift = shifted;
    case (fr_reg.phase)
      acgcd_pkg::PH_CMD:
      begin
        if (fr_reg.cnt == acgcd_pkg::CMD_LAST)
        begin
          fr_next.cnt = 4'h0;
          if (cmd_byte[7:5] == acgcd_pkg::AVG_SEL_PAT)
          begin
            lk_next.tgl = ~lk_reg.tgl;
            lk_next.kind = acgcd_pkg::EV_AVG;
            lk_next.word = {8'h00, cmd_byte};
          end
          else if (cmd_byte[7:4] == acgcd_pkg::DAC_SEL_PAT)
            fr_next.phase = acgcd_pkg::PH_DAC;
          else if (cmd_byte[7:3] == acgcd_pkg::RST_SEL_PAT)
          begin
            lk_next.tgl = ~lk_reg.tgl;
            lk_next.kind = acgcd_pkg::EV_RST;
            lk_next.word = {8'h00, cmd_byte};
          end
          else if (cmd_byte[7:2] == acgcd_pkg::PIN_SEL_PAT)
          begin
            if (cmd_byte[1:0] == acgcd_pkg::PIN_CFG_CODE)
            begin
              fr_next.phase = acgcd_pkg::PH_PWR;
              fr_next.wr_kind = 1'b0;
            end
            else if (cmd_byte[1:0] == acgcd_pkg::PIN_WR_CODE)
            begin
              fr_next.phase = acgcd_pkg::PH_PWR;
              fr_next.wr_kind = 1'b1;
            end
            else if (cmd_byte[1:0] == acgcd_pkg::PIN_RD_CODE)
            begin
              // Pin byte goes out low nibble last, first bit now
              fr_next.phase = acgcd_pkg::PH_PRD;
              fr_next.dout = 1'b0;
              fr_next.shift = {8'h00, 3'h0, lk_reg.pin_s2, 1'b0};
            end
          end
        end
      end
      acgcd_pkg::PH_DAC:
      begin
        if (fr_reg.cnt == acgcd_pkg::DAC_LAST)
        begin
          fr_next.cnt = 4'h0;
          fr_next.phase = acgcd_pkg::PH_CMD;
          lk_next.tgl = ~lk_reg.tgl;
          lk_next.kind = acgcd_pkg::EV_DAC;
          lk_next.word = shifted;
        end
      end
      acgcd_pkg::PH_PWR:
      begin
        if (fr_reg.cnt == acgcd_pkg::PIN_LAST)
        begin
          fr_next.cnt = 4'h0;
          fr_next.phase = acgcd_pkg::PH_CMD;
          lk_next.tgl = ~lk_reg.tgl;
          lk_next.kind = fr_reg.wr_kind ? acgcd_pkg::EV_WR : acgcd_pkg::EV_CFG;
          lk_next.word = {8'h00, cmd_byte};
        end
      end
      acgcd_pkg::PH_PRD:
      begin
        fr_next.dout = fr_reg.shift[7];
        fr_next.shift = {fr_reg.shift[14:0], 1'b0};
        if (fr_reg.cnt == acgcd_pkg::PIN_LAST)
        begin
          fr_next.cnt = 4'h0;
          fr_next.phase = acgcd_pkg::PH_CMD;
        end
      end
      default:
      begin
        fr_next = FRAME_RESET;
      end
    endcase
  end

  always_ff @(negedge link_sclk_i or posedge frame_clr)
  begin
    if (frame_clr)
      fr_reg <= FRAME_RESET;
    else
      fr_reg <= fr_next;
  end

  // Event word and toggle outlive the frame
  always_ff @(negedge link_sclk_i or posedge reset_i)
  begin
    if (reset_i)
      lk_reg <= LINK_RESET;
    else
      lk_reg <= lk_next;
  end

  assign dout_o = fr_reg.dout;

  // System clock side
  logic evt;
  logic eff_avg;
  assign evt = core_reg.tg_s2 ^ core_reg.tg_s3;

  always_comb
  begin
    core_next = core_reg;
    core_next.cs_s1 = cs_n_i;
    core_next.cs_s2 = core_reg.cs_s1;
    core_next.tg_s1 = lk_reg.tgl;
    core_next.tg_s2 = core_reg.tg_s1;
    core_next.tg_s3 = core_reg.tg_s2;
    core_next.dac_stb = 1'b0;
    core_next.fifo_clr = 1'b0;
    core_next.regs_rst = 1'b0;
    // Word is stable for many sclk periods after its toggle
    if (evt)
    begin
      case (lk_reg.kind)
        acgcd_pkg::EV_AVG:
          core_next.avg = lk_reg.word[4:0];
        acgcd_pkg::EV_RST:
        begin
          core_next.fifo_clr = 1'b1;
          core_next.slow = lk_reg.word[acgcd_pkg::RST_SLOW_BIT];
          core_next.fbg = lk_reg.word[acgcd_pkg::RST_FBG_BIT];
          if (lk_reg.word[acgcd_pkg::RST_FULL_BIT])
          begin
            // Pin and DAC state stay as they are
            core_next.regs_rst = 1'b1;
            core_next.avg = acgcd_pkg::AVG_RESET;
          end
        end
        acgcd_pkg::EV_DAC:
        begin
          core_next.dac_word = lk_reg.word;
          core_next.dac_stb = 1'b1;
        end
        acgcd_pkg::EV_CFG:
        begin
          core_next.cfg_pend = 1'b1;
          core_next.cfg_data = lk_reg.word[7:4];
        end
        acgcd_pkg::EV_WR:
        begin
          core_next.wr_pend = 1'b1;
          core_next.wr_data = lk_reg.word[7:4];
        end
        default:
        begin
          core_next.avg = core_reg.avg;
        end
      endcase
    end
    // Pin registers follow only once chip select is back high
    if (core_reg.cs_s2 && core_reg.cfg_pend && !(evt && lk_reg.kind == acgcd_pkg::EV_CFG))
    begin
      core_next.cfg = core_reg.cfg_data;
      core_next.cfg_pend = 1'b0;
    end
    if (core_reg.cs_s2 && core_reg.wr_pend && !(evt && lk_reg.kind == acgcd_pkg::EV_WR))
    begin
      core_next.wr = core_reg.wr_data;
      core_next.wr_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      core_reg <= '0;
      core_reg.cs_s1 <= 1'b1;
      core_reg.cs_s2 <= 1'b1;
      core_reg.avg <= acgcd_pkg::AVG_RESET;
      core_reg.cfg <= acgcd_pkg::PIN_CFG_RESET;
      core_reg.wr <= acgcd_pkg::PIN_WR_RESET;
    end
    else
      core_reg <= core_next;
  end

  // Derived controls for the conversion engine
  assign eff_avg = core_reg.avg[acgcd_pkg::AVG_EN_BIT] && (clock_mode_i != acgcd_pkg::CLK_MODE_11);
  assign averaging_enable_o = eff_avg;
  assign average_depth_o = core_reg.avg[acgcd_pkg::AVG_DEPTH_LSB +: 2];
  assign repeat_count_o = core_reg.avg[acgcd_pkg::AVG_COUNT_LSB +: 2];

  always_comb
  begin
    conversions_per_result_o = 6'h01;
    if (eff_avg)
    begin
      case (average_depth_o)
        2'h0: conversions_per_result_o = 6'h04;
        2'h1: conversions_per_result_o = 6'h08;
        2'h2: conversions_per_result_o = 6'h10;
        default: conversions_per_result_o = 6'h20;
      endcase
    end
    // Zero means the count does not apply in this scan mode
    scan_results_o = 5'h00;
    if (scan_mode_i == acgcd_pkg::SCAN_REPEAT)
      // Fifth bit holds the count of 16, which a 4-bit sum would wrap to zero
      scan_results_o = {1'b0, repeat_count_o, 2'h0} + 5'h04;
  end

  assign fifo_clear_o = core_reg.fifo_clr;
  assign regs_reset_o = core_reg.regs_rst;
  assign setup_reset_value_o = acgcd_pkg::SETUP_RESET;
  // Delay cell sits in the pad; only the select is produced here
  assign slow_mode_o = core_reg.slow;
  assign force_reference_on_o = core_reg.fbg;
  assign wake_delay_bypass_o = core_reg.fbg && (clock_mode_i == acgcd_pkg::CLK_MODE_01 ||
    clock_mode_i == acgcd_pkg::CLK_MODE_11);
  assign dac_word_o = core_reg.dac_word;
  assign dac_strobe_o = core_reg.dac_stb;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      // Config 0 with write 0 is an open-drain pull-down
      assign pin_o[gi] = core_reg.cfg[gi] & core_reg.wr[gi];
      assign pin_oe_n_o[gi] = ~(core_reg.cfg[gi] | ~core_reg.wr[gi]);
    end
  endgenerate

  // Checks
  sequence s_evt_kind(acgcd_pkg::acgcd_event_t k);
    evt && lk_reg.kind == k;
  endsequence

  sequence s_full_reset;
    evt && lk_reg.kind == acgcd_pkg::EV_RST && lk_reg.word[acgcd_pkg::RST_FULL_BIT];
  endsequence

  avg_write_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_evt_kind(acgcd_pkg::EV_AVG) |=> core_reg.avg == $past(lk_reg.word[4:0]))
    else $error("averaging register not loaded");

  conv_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (core_reg.avg[4:2] == 3'h7 && clock_mode_i != acgcd_pkg::CLK_MODE_11) |-> conversions_per_result_o == 6'h20)
    else $error("depth 11 not 32 conversions");

  avg_forced_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    clock_mode_i == acgcd_pkg::CLK_MODE_11 |-> !averaging_enable_o && conversions_per_result_o == 6'h01)
    else $error("averaging active in clock mode 11");

  scan_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (scan_mode_i == acgcd_pkg::SCAN_REPEAT && core_reg.avg[1:0] == 2'h2) |-> scan_results_o == 5'h0C)
    else $error("scan count 10 not 12 results");

  dac_forward_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_evt_kind(acgcd_pkg::EV_DAC) |=> dac_strobe_o && dac_word_o == $past(lk_reg.word) ##1 !dac_strobe_o)
    else $error("dac word not forwarded as one pulse");

  fifo_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_evt_kind(acgcd_pkg::EV_RST) |=> fifo_clear_o)
    else $error("reset write did not clear fifo");

  full_reset_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_full_reset |=> regs_reset_o && core_reg.avg == 5'h00 && $stable(pin_o) && $stable(dac_word_o))
    else $error("full reset wrong scope");

  pin_apply_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (core_reg.cs_s2 && core_reg.cfg_pend && !evt) |=> core_reg.cfg == $past(core_reg.cfg_data) && !core_reg.cfg_pend)
    else $error("pin configuration not applied");

  pin_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!core_reg.cs_s2) [*2] |-> $stable(core_reg.wr))
    else $error("pin write changed during frame");

  dac_frame_a: assert property (@(negedge link_sclk_i) disable iff (frame_clr)
    (fr_reg.phase == acgcd_pkg::PH_DAC && fr_reg.cnt != acgcd_pkg::DAC_LAST) |=> $stable(lk_reg.tgl))
    else $error("dac event before 16 clocks");

endmodule // acgcd_decoder

`default_nettype wire

/* testbench/acgcd_host.sv */
`timescale 1ns/1ps
`default_nettype none

module acgcd_host (
  input wire logic go_i,
  input wire logic [5:0] nbits_i,
  input wire logic [31:0] data_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic busy_o,
  output logic [7:0] rdata_o
);
  initial
  begin
    sclk_o = 1'b0;
    din_o = 1'b0;
    busy_o = 1'b0;
    rdata_o = 8'h00;
    // Raised after time zero so the frame clear sees a real rising edge
    #1 cs_n_o = 1'b1;
  end

  // Odd start offset keeps the link clock unrelated to mclk
  always @(posedge go_i)
  begin
    busy_o = 1'b1;
    #13 cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--)
      if (i < nbits_i)
      begin
        #40 sclk_o = 1'b1;
        rdata_o = {rdata_o[6:0], dout_i};
        din_o = data_i[i];
        #40 sclk_o = 1'b0;
      end
    #40 cs_n_o = 1'b1;
    // No pull on the data line, so show the inverse once released
    din_o = ~din_o;
    busy_o = 1'b0;
  end
endmodule // acgcd_host

`default_nettype wire

/* testbench/adc_dac_gpio_command_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_dac_gpio_command_decoder_bench;
  logic mclk = 1'b0;
  logic rst = 1'b0;
  logic sclk, cs_n, din, dout, avg_en, fclr, rrst, slow, fbg, wbyp, dstb, go, busy, en;
  logic [1:0] scan_mode, clock_mode, depth, rcount;
  logic [5:0] conv, nbits, e_conv;
  logic [4:0] sres;
  logic [7:0] setup_v, rdata;
  logic [15:0] dword, last_dac;
  logic [3:0] pin_in, pin_out, pin_oe_n, ext;
  logic [31:0] hdata, r;
  logic [15:0] dq[$];
  logic cq[$];
  int fail_count = 0;
  int compares = 0;
  int seed = 32'h3d20;

  always #12.5 mclk = ~mclk;

  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);

  acgcd_host u_acgcd_host (.go_i(go), .nbits_i(nbits), .data_i(hdata), .dout_i(dout), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din), .busy_o(busy), .rdata_o(rdata));

  acgcd_decoder #(.NPINS(4)) u_acgcd_decoder (.mclk_i(mclk), .reset_i(rst), .link_sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .scan_mode_i(scan_mode), .clock_mode_i(clock_mode),
    .averaging_enable_o(avg_en), .average_depth_o(depth), .repeat_count_o(rcount),
    .conversions_per_result_o(conv), .scan_results_o(sres), .fifo_clear_o(fclr), .regs_reset_o(rrst),
    .setup_reset_value_o(setup_v), .slow_mode_o(slow), .force_reference_on_o(fbg),
    .wake_delay_bypass_o(wbyp), .dac_word_o(dword), .dac_strobe_o(dstb), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_n_o(pin_oe_n));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input int n, input logic [31:0] d);
    int t;
    @(negedge mclk);
    nbits = n[5:0];
    hdata = d;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    for (t = 0; t < 4000 && busy === 1'b1; t++)
      @(negedge mclk);
    if (busy !== 1'b0)
    begin
      fail_count++;
      final_report();
    end
    // Effects land 3..4 mclk after the frame
    repeat (8) @(negedge mclk);
  endtask

  always @(negedge mclk)
  begin
    if (dstb === 1'b1)
    begin
      if (dq.size() == 0)
        chk("dac_strobe", 16'h0000, 16'h0001);
      else
        chk("dac_word", dq.pop_front(), dword);
    end
    if (fclr === 1'b1)
    begin
      if (cq.size() == 0)
        chk("fifo_clear", 16'h0000, 16'h0001);
      else
        chk("regs_reset", {15'h0000, cq.pop_front()}, {15'h0000, rrst});
    end
  end

  initial
  begin
    go = 1'b0;
    nbits = 6'h00;
    hdata = 32'h0000_0000;
    scan_mode = 2'h0;
    clock_mode = 2'h0;
    ext = 4'h0;
    // Async resets need an edge after time zero, not an initial level
    #1 rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("avg_fields", 16'h0000, {11'h000, avg_en, depth, rcount});
    chk("setup_value", 16'h0060, {8'h00, setup_v});
    chk("pin_oe_n", 16'h000F, {12'h000, pin_oe_n});
    chk("slow_fbg", 16'h0000, {14'h0000, slow, fbg});
    for (int k = 0; k < 16; k++)
    begin
      r = $random(seed);
      en = (k == 5) ? 1'b1 : (k == 2) ? 1'b0 : r[0];
      scan_mode = (k[0] || k == 6) ? 2'h2 : r[2:1];
      clock_mode = (k == 5) ? 2'h3 : r[4:3];
      send(8, {24'h000000, 3'h1, en, k[3:0]});
      e_conv = (en && clock_mode != 2'h3) ? (6'h04 << k[3:2]) : 6'h01;
      chk("avg_enable", {15'h0000, en && clock_mode != 2'h3}, {15'h0000, avg_en});
      chk("avg_fields", {12'h000, k[3:0]}, {12'h000, depth, rcount});
      chk("conversions", {10'h000, e_conv}, {10'h000, conv});
      chk("scan_results", (scan_mode == 2'h2) ? 16'(4 * (k[1:0] + 1)) : 16'h0000, {11'h000, sres});
    end
    for (int k = 0; k < 5; k++)
    begin
      r = $random(seed);
      dq.push_back(r[15:0]);
      send(24, {8'h00, 4'h1, r[19:16], r[15:0]});
    end
    last_dac = r[15:0];
    send(18, {14'h0000, 4'h1, 4'h0, 10'h3FF});
    chk("dac_hold", last_dac, dword);
    send(16, {16'h0000, 8'h03, 8'hA0});
    send(16, {16'h0000, 8'h02, 8'h60});
    chk("pin_oe_n", 16'h0004, {12'h000, pin_oe_n});
    chk("pin_out", 16'h0002, {12'h000, pin_out});
    r = $random(seed);
    ext = r[3:0];
    send(16, {16'h0000, 8'h01, 8'hFF});
    chk("pin_read", {8'h00, 4'h0, 4'b0010 | (4'b0100 & ext)}, {8'h00, rdata});
    cq.push_back(1'b1);
    send(8, 32'h0000_000E);
    chk("avg_fields", 16'h0000, {11'h000, avg_en, depth, rcount});
    chk("slow", 16'h0001, {15'h0000, slow});
    chk("pin_kept", 16'h0004, {12'h000, pin_oe_n});
    chk("dac_kept", last_dac, dword);
    clock_mode = 2'h1;
    send(8, 32'h0000_003F);
    cq.push_back(1'b0);
    send(8, 32'h0000_0009);
    chk("avg_kept", 16'h001F, {11'h000, avg_en, depth, rcount});
    chk("fbg_slow", 16'h0001, {14'h0000, slow, fbg});
    chk("wake_bypass", 16'h0001, {15'h0000, wbyp});
    clock_mode = 2'h3;
    @(negedge mclk);
    chk("wake_bypass", 16'h0001, {15'h0000, wbyp});
    chk("avg_enable", 16'h0000, {15'h0000, avg_en});
    clock_mode = 2'h0;
    @(negedge mclk);
    chk("wake_bypass", 16'h0000, {15'h0000, wbyp});
    chk("queues_empty", 16'h0000, 16'(dq.size() + cq.size()));
    final_report();
  end
endmodule // adc_dac_gpio_command_decoder_bench

`default_nettype wire
